// ### drive_seq_pkg.sv
// How it works
// - Command reactions follow one state machine
// - State code 0..7 in documented order
// - Code 0 ignores switch-on commands
// - Code 1 accepts a switch-on command
// - Code 2 enables the power stack
// - Code 3 waits for enable, contactor held closed
// - Code 4 drives motor, fully enabled
// - Code 6 handles fault before tripped
// - Code 7 holds until fault clear
// - Lowest numbered transition wins on conflict
// - Switched on trips after 10 s with contactor open
// - Leave tripped on clear rise, fault gone
// - Arm only with run, inch low, halts high
package drive_seq_pkg;
   // Main state, declaration order gives the reported code
   typedef enum logic [2:0] {
      ST_SWITCH_ON_DISABLED,
      ST_READY_TO_SWITCH_ON,
      ST_SWITCHED_ON,
      ST_READY,
      ST_ENABLED,
      ST_QUICK_HALT,
      ST_TRIP_ACTIVE,
      ST_TRIPPED
   } main_state_e;

   // Clock rate and the contactor wait time
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CONTACTOR_WAIT_S = 10;
   localparam int unsigned CONTACTOR_WAIT_CYC = CLK_HZ * CONTACTOR_WAIT_S;
   localparam int unsigned TIMER_W = 28;

   // Commands from terminals, keypad or fieldbus
   typedef struct packed {
      logic run;          // Run request
      logic inch;         // Jog request
      logic enable;       // Enable operation
      logic coast_halt_n; // Coast halt, active low
      logic quick_halt_n; // Quick halt, active low
      logic fault_clear;  // Fault clear request
   } cmd_s;

   // Feedback from power stage and contactor
   typedef struct packed {
      logic fault;           // Trip condition present
      logic contactor_closed; // Output contactor confirmed closed
      logic defluxed;        // Motor flux decayed
      logic stop_done;       // Normal stopping finished
      logic halt_done;       // Quick halt finished
      logic stack_quenched;  // Power stack off after trip
   } fbk_s;
endpackage

// ### drive_seq_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin inputs
module drive_seq_sync #(
   parameter int unsigned W = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q; // First stage, read only by second stage
   logic [W-1:0] sync_q; // Second stage

   // Two stages; metastability settles in the first
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

// ### drive_seq_fsm.sv
`timescale 1ns/1ps
// Main sequencing state machine of the drive
module drive_seq_fsm #(
   parameter int unsigned CONTACTOR_WAIT_CYC = drive_seq_pkg::CONTACTOR_WAIT_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire drive_seq_pkg::cmd_s i_cmd,
   input wire drive_seq_pkg::fbk_s i_fbk,
   output logic [2:0] o_main_state_code,
   output logic o_stack_enable,
   output logic o_drive_active,
   output logic o_contactor_timeout
);
   localparam int CMD_W = $bits(drive_seq_pkg::cmd_s);
   localparam int FBK_W = $bits(drive_seq_pkg::fbk_s);
   localparam int TW = drive_seq_pkg::TIMER_W;
   localparam logic [TW-1:0] WAIT_LAST = TW'(CONTACTOR_WAIT_CYC - 1);

   drive_seq_pkg::cmd_s cmd; // Synchronised commands
   drive_seq_pkg::fbk_s fbk; // Synchronised feedback
   logic [CMD_W-1:0] cmd_raw;
   logic [FBK_W-1:0] fbk_raw;

   // All inputs come from pins, so they cross in two flops
   drive_seq_sync #(.W(CMD_W + FBK_W)) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_async({i_cmd, i_fbk}),
      .o_sync({cmd_raw, fbk_raw})
   );
   assign cmd = drive_seq_pkg::cmd_s'(cmd_raw);
   assign fbk = drive_seq_pkg::fbk_s'(fbk_raw);

   drive_seq_pkg::main_state_e state_q, state_d; // Main state
   logic [TW-1:0] timer_q, timer_d;  // Contactor wait counter
   logic clear_prev_q, clear_prev_d; // Previous fault clear level
   logic tmo_q, tmo_d;               // Contactor timeout latched
   logic stack_q, stack_d; // Power stack enable, registered
   logic active_q, active_d; // Motor driven, registered
   logic clear_rise;                 // Fault clear edge
   logic halt_any;                   // Either halt input asserted
   logic no_demand;                  // Run and inch both low
   logic tmo_hit;                    // Wait elapsed without contactor

   assign clear_rise = cmd.fault_clear && !clear_prev_q;
   assign halt_any = !cmd.coast_halt_n || !cmd.quick_halt_n;
   assign no_demand = !cmd.run && !cmd.inch;
   assign tmo_hit = (state_q == drive_seq_pkg::ST_SWITCHED_ON) && !fbk.contactor_closed
      && (timer_q == WAIT_LAST);

   // Next state; each state checks exits in ascending transition order
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         drive_seq_pkg::ST_SWITCH_ON_DISABLED: begin
            // Run commands alone never leave here
            if (fbk.fault) begin
               state_d = drive_seq_pkg::ST_TRIP_ACTIVE;
            end else if (no_demand && !halt_any) begin
               state_d = drive_seq_pkg::ST_READY_TO_SWITCH_ON;
            end
         end
         drive_seq_pkg::ST_READY_TO_SWITCH_ON: begin
            if (fbk.fault) begin
               state_d = drive_seq_pkg::ST_TRIP_ACTIVE;
            end else if (halt_any) begin
               state_d = drive_seq_pkg::ST_SWITCH_ON_DISABLED;
            end else if (cmd.run || cmd.inch) begin
               state_d = drive_seq_pkg::ST_SWITCHED_ON;
            end
         end
         drive_seq_pkg::ST_SWITCHED_ON: begin
            if (fbk.fault || tmo_hit) begin
               state_d = drive_seq_pkg::ST_TRIP_ACTIVE;
            end else if (halt_any) begin
               state_d = drive_seq_pkg::ST_SWITCH_ON_DISABLED;
            end else if (no_demand) begin
               state_d = drive_seq_pkg::ST_READY_TO_SWITCH_ON;
            end else if (fbk.contactor_closed && fbk.defluxed) begin
               state_d = drive_seq_pkg::ST_READY;
            end
         end
         drive_seq_pkg::ST_READY: begin
            // Contactor must stay closed once confirmed
            if (fbk.fault || !fbk.contactor_closed) begin
               state_d = drive_seq_pkg::ST_TRIP_ACTIVE;
            end else if (halt_any) begin
               state_d = drive_seq_pkg::ST_SWITCH_ON_DISABLED;
            end else if (no_demand) begin
               state_d = drive_seq_pkg::ST_READY_TO_SWITCH_ON;
            end else if (cmd.enable) begin
               state_d = drive_seq_pkg::ST_ENABLED;
            end
         end
         drive_seq_pkg::ST_ENABLED: begin
            if (fbk.fault || !fbk.contactor_closed) begin
               state_d = drive_seq_pkg::ST_TRIP_ACTIVE;
            end else if (!cmd.coast_halt_n) begin
               state_d = drive_seq_pkg::ST_SWITCH_ON_DISABLED;
            end else if (!cmd.quick_halt_n) begin
               state_d = drive_seq_pkg::ST_QUICK_HALT;
            end else if (no_demand && fbk.stop_done) begin
               state_d = drive_seq_pkg::ST_READY_TO_SWITCH_ON;
            end else if (!cmd.enable) begin
               state_d = drive_seq_pkg::ST_READY;
            end
         end
         drive_seq_pkg::ST_QUICK_HALT: begin
            if (fbk.fault || !fbk.contactor_closed) begin
               state_d = drive_seq_pkg::ST_TRIP_ACTIVE;
            end else if (fbk.halt_done) begin
               state_d = drive_seq_pkg::ST_SWITCH_ON_DISABLED;
            end
         end
         drive_seq_pkg::ST_TRIP_ACTIVE: begin
            // Wait for the stack to stop switching
            if (fbk.stack_quenched) begin
               state_d = drive_seq_pkg::ST_TRIPPED;
            end
         end
         drive_seq_pkg::ST_TRIPPED: begin
            if (!fbk.fault && clear_rise) begin
               state_d = drive_seq_pkg::ST_SWITCH_ON_DISABLED;
            end
         end
      endcase
   end

   // Timer, edge memory and timeout flag
   always_comb begin
      clear_prev_d = cmd.fault_clear;
      // Count only while in switched on; restarts on each entry
      if (state_q == drive_seq_pkg::ST_SWITCHED_ON && timer_q != WAIT_LAST) begin
         timer_d = timer_q + TW'(1);
      end else if (state_q == drive_seq_pkg::ST_SWITCHED_ON) begin
         timer_d = timer_q;
      end else begin
         timer_d = '0;
      end
      // Timeout stays visible until the trip is cleared
      if (tmo_hit) begin
         tmo_d = 1'b1;
      end else if (state_q == drive_seq_pkg::ST_TRIPPED && state_d != state_q) begin
         tmo_d = 1'b0;
      end else begin
         tmo_d = tmo_q;
      end
      // Flags decode the next state so they change on the same edge as the code
      stack_d = (state_d inside {drive_seq_pkg::ST_SWITCHED_ON, drive_seq_pkg::ST_READY,
         drive_seq_pkg::ST_ENABLED, drive_seq_pkg::ST_QUICK_HALT});
      active_d = (state_d == drive_seq_pkg::ST_ENABLED);
   end

   // Registers only
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= drive_seq_pkg::ST_SWITCH_ON_DISABLED;
         timer_q <= '0;
         clear_prev_q <= 1'b1;
         tmo_q <= 1'b0;
         stack_q <= 1'b0;
         active_q <= 1'b0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         clear_prev_q <= clear_prev_d;
         tmo_q <= tmo_d;
         stack_q <= stack_d;
         active_q <= active_d;
      end
   end

   assign o_main_state_code = state_q;
   // Registered so the power stage never sees a decode glitch
   assign o_stack_enable = stack_q;
   assign o_drive_active = active_q;
   assign o_contactor_timeout = tmo_q;

   sequence s_stuck_open;
      (state_q == drive_seq_pkg::ST_SWITCHED_ON) && tmo_hit;
   endsequence

   AST_RESET_CODE: assert property (@(posedge i_ref_clk)
      $rose(i_reset_n) |-> o_main_state_code == 3'h0)
      else $error("state not zero after reset");
   AST_CODE_MATCH: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      ((o_main_state_code == 3'h6) == (state_q == drive_seq_pkg::ST_TRIP_ACTIVE))
      && ((o_main_state_code == 3'h7) == (state_q == drive_seq_pkg::ST_TRIPPED)))
      else $error("code order wrong");
   AST_NO_SKIP_ON: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      state_q == drive_seq_pkg::ST_SWITCH_ON_DISABLED |=>
      state_q != drive_seq_pkg::ST_SWITCHED_ON) else $error("switch-on from disabled");
   AST_ACCEPT_ON: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      state_q == drive_seq_pkg::ST_READY_TO_SWITCH_ON && !fbk.fault && !halt_any
      && (cmd.run || cmd.inch)
      |=> state_q == drive_seq_pkg::ST_SWITCHED_ON) else $error("switch-on not accepted");
   AST_STACK: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      state_q == drive_seq_pkg::ST_SWITCHED_ON |-> o_stack_enable) else $error("stack off");
   AST_READY_NEEDS_CONT: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(state_q == drive_seq_pkg::ST_READY) |-> $past(fbk.contactor_closed))
      else $error("ready without contactor");
   AST_ACTIVE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_drive_active == (state_q == drive_seq_pkg::ST_ENABLED)) else $error("active wrong");
   AST_TRIP_SEQ: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(state_q == drive_seq_pkg::ST_TRIPPED) |->
      $past(state_q) == drive_seq_pkg::ST_TRIP_ACTIVE) else $error("tripped skipped");
   AST_HOLD_TRIP: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      state_q == drive_seq_pkg::ST_TRIPPED && !clear_rise |=>
      state_q == drive_seq_pkg::ST_TRIPPED) else $error("left tripped");
   AST_PRIORITY: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      state_q inside {[drive_seq_pkg::ST_SWITCH_ON_DISABLED:drive_seq_pkg::ST_QUICK_HALT]}
      && fbk.fault |=> state_q == drive_seq_pkg::ST_TRIP_ACTIVE) else $error("trip not first");
   // A trip must drop the stack at once, not after the fault settles
   AST_TRIP_STACK_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      state_q == drive_seq_pkg::ST_TRIP_ACTIVE |-> !o_stack_enable) else $error("stack on in trip");
   AST_TIMEOUT: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      s_stuck_open |=> state_q == drive_seq_pkg::ST_TRIP_ACTIVE && o_contactor_timeout)
      else $error("contactor timeout missed");
   AST_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $past(state_q) == drive_seq_pkg::ST_TRIPPED && state_q != drive_seq_pkg::ST_TRIPPED
      |-> $past(clear_rise) && !$past(fbk.fault)) else $error("bad trip clear");
   AST_ARM: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(state_q == drive_seq_pkg::ST_READY_TO_SWITCH_ON)
      && $past(state_q) == drive_seq_pkg::ST_SWITCH_ON_DISABLED
      |-> $past(no_demand) && !$past(halt_any)) else $error("armed wrongly");
endmodule

// ### power_stage_model.sv
`timescale 1ns/1ps
// Behavioural power stage and output contactor
module power_stage_model (
   input wire logic i_ref_clk,
   input wire logic i_stack_enable,
   input wire logic i_fault,
   input wire logic i_block_close,
   input wire logic [2:0] i_delay,
   output drive_seq_pkg::fbk_s o_fbk
);
   logic [3:0] cnt_q; // Cycles since the stack came on
   logic quench_q; // Stack off, one cycle behind its enable
   logic ok; // Contactor closed and motor settled
   // Contactor needs a few cycles; a blocked one never closes
   assign ok = i_stack_enable && !i_block_close && (cnt_q > {1'b0, i_delay});
   // Order: fault, closed, defluxed, stop done, halt done, quenched
   assign o_fbk = {i_fault, ok, ok, ok, ok, quench_q};
   // Settle counter restarts whenever the stack drops
   always_ff @(posedge i_ref_clk) begin
      if (!i_stack_enable) begin
         cnt_q <= 4'h0;
      end else if (cnt_q != 4'hF) begin
         cnt_q <= cnt_q + 4'h1;
      end
      quench_q <= !i_stack_enable;
   end
endmodule

// ### drive_main_state_code_machine_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the drive sequencer
module drive_main_state_code_machine_tb_top;
   logic i_ref_clk = 1'b0;
   logic i_reset_n = 1'b0;
   drive_seq_pkg::cmd_s cmd = 6'h26; // Run high, both halts released
   drive_seq_pkg::fbk_s fbk; // From the power stage model
   logic fault = 1'b0; // Trip condition shown by the stage
   logic block = 1'b0; // Holds the contactor open
   logic [2:0] dly = 3'h0; // Contactor settle time
   logic sw = 1'b0; // Random pick of run or inch as switch-on demand
   logic [2:0] code;
   logic stk;
   logic act;
   logic tmo;
   logic [2:0] exp_q[$]; // Expected codes, oldest first
   logic [2:0] last = 3'h0; // Last code seen
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   int seed = 35;
   drive_seq_fsm #(.CONTACTOR_WAIT_CYC(20)) drive_seq_fsm_inst (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_cmd(cmd),
      .i_fbk(fbk),
      .o_main_state_code(code),
      .o_stack_enable(stk),
      .o_drive_active(act),
      .o_contactor_timeout(tmo)
   );
   power_stage_model power_stage_model_inst (
      .i_ref_clk(i_ref_clk),
      .i_stack_enable(stk),
      .i_fault(fault),
      .i_block_close(block),
      .i_delay(dly),
      .o_fbk(fbk)
   );
   // Free-running 20 MHz clock
   initial begin
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // Compare and count
   task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // Single exit point of the run
   task automatic report_and_stop();
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Queue a code and wait, bounded, until all notes are consumed
   task automatic expect_to(input logic [2:0] c);
      int n;
      n = 0;
      exp_q.push_back(c);
      while (exp_q.size() != 0 && n < 60) begin
         @(negedge i_ref_clk);
         n++;
      end
      if (exp_q.size() != 0) begin
         check("arrival", 3'h1, 3'h0);
         exp_q.delete();
      end
   endtask
   // Each code change takes the oldest note; a change without one is wrong
   always @(negedge i_ref_clk) begin
      if (i_reset_n && code !== last) begin
         if (exp_q.size() == 0) begin
            check("unexpected code", code, last);
         end else begin
            check("state code", code, exp_q[0]);
            check("stack", {2'h0, stk}, {2'h0, exp_q[0] inside {[3'h2:3'h5]}});
            check("active", {2'h0, act}, {2'h0, exp_q[0] == 3'h4});
            void'(exp_q.pop_front());
         end
         last = code;
      end
   end
   // Hang guard, well above the hundred or so cycles needed
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   // Stimulus, changed at falling edges only
   initial begin
      repeat (5) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      check("reset code", code, 3'h0);
      // Switch-on held while disabled must not move the state
      repeat (10) begin
         cmd.enable = 1'($random(seed));
         cmd.inch = 1'($random(seed));
         cmd.fault_clear = 1'($random(seed));
         @(negedge i_ref_clk);
      end
      cmd.enable = 1'b0;
      cmd.inch = 1'b0;
      cmd.fault_clear = 1'b0;
      cmd.run = 1'b0;
      expect_to(3'h1);
      $display("test arm done");
      dly = 3'($random(seed));
      sw = 1'($random(seed));
      cmd.run = sw;
      cmd.inch = !sw;
      exp_q.push_back(3'h2);
      expect_to(3'h3);
      cmd.enable = 1'b1;
      expect_to(3'h4);
      cmd.quick_halt_n = 1'b0;
      exp_q.push_back(3'h5);
      expect_to(3'h0);
      cmd.quick_halt_n = 1'b1;
      cmd.enable = 1'b0;
      repeat (8) @(negedge i_ref_clk);
      cmd.run = 1'b0;
      cmd.inch = 1'b0;
      expect_to(3'h1);
      $display("test run and halt done");
      // Contactor never closes: timed trip
      block = 1'b1;
      cmd.run = 1'b1;
      exp_q.push_back(3'h2);
      exp_q.push_back(3'h6);
      expect_to(3'h7);
      check("timeout flag", {2'h0, tmo}, 3'h1);
      $display("test timeout done");
      // Clear edge while the fault persists is ignored
      fault = 1'b1;
      cmd.fault_clear = 1'b1;
      repeat (8) @(negedge i_ref_clk);
      cmd.fault_clear = 1'b0;
      fault = 1'b0;
      block = 1'b0;
      cmd.run = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      cmd.fault_clear = 1'b1;
      exp_q.push_back(3'h0);
      expect_to(3'h1);
      check("timeout cleared", {2'h0, tmo}, 3'h0);
      $display("test clear done");
      // Trip and switch-on together: trip wins
      fault = 1'b1;
      cmd.run = 1'b1;
      exp_q.push_back(3'h6);
      expect_to(3'h7);
      fault = 1'b0;
      cmd.run = 1'b0;
      cmd.fault_clear = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      cmd.fault_clear = 1'b1;
      exp_q.push_back(3'h0);
      expect_to(3'h1);
      cmd.coast_halt_n = 1'b0;
      expect_to(3'h0);
      cmd.coast_halt_n = 1'b1;
      expect_to(3'h1);
      $display("test priority done");
      report_and_stop();
   end
endmodule
